// ### design/serial_control_frame_receiver.sv
// Serial control frame receiver with sync detect, framing, enable and monitor pulses
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module serial_control_frame_receiver
  import frame_rx_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link pins
  input wire logic link_clk_pin,
  input wire logic link_data_pin,
  input wire logic power_fail_pin,
  input wire logic single_freq_select_n_pin,
  // Receiver outputs
  output logic transmit_keying_n,
  output logic enable_pulse,
  output logic monitor_load,
  output logic eof_pulse,
  output logic freq_serial_entry,
  output logic frame_error,
  output logic reply_sync_data,
  output logic rise_pulse_n,
  output logic fall_pulse,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [3:0] pin_s;
  logic clk_s, data_s, pfail_s, sel_n_s;
  logic link_clk_prev_q;
  logic link_rise, link_fall;
  logic shifted_q;
  logic [7:0] sync_shift_register;
  logic [39:0] word_input_register;
  logic [39:0] prev_word_q;
  logic framing_flip_flop;
  logic [5:0] bit_cnt_q;
  logic input_clock_gate;
  logic [1:0] txrx;
  logic [1:0] last_txrx_q;
  logic txrx_compare_gate;
  logic sync_valid, five_ones_seen, eof_now;
  logic [3:0] word_identifier;
  logic cmp_ok, control_inhibit_bit, return_monitor_bit, sff_bypass, enable_now, monload_now;
  logic [1:0] fail_cnt_q;
  logic [7:0] reply_sync_generator;
  logic rise_busy, fall_busy;
  logic rx_enable_q;
  logic [15:0] frames_q;

  // Pin synchronisers and link edge detect
  sync_2ff #(.W(4)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({single_freq_select_n_pin, power_fail_pin, link_data_pin, link_clk_pin}),
    .q(pin_s)
  );

  assign clk_s = pin_s[0];
  assign data_s = pin_s[1];
  assign pfail_s = pin_s[2];
  assign sel_n_s = pin_s[3];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_clk_prev_q <= 1'b0;
      shifted_q <= 1'b0;
    end else begin
      link_clk_prev_q <= clk_s;
      shifted_q <= link_fall;
    end
  end

  assign link_rise = clk_s & ~link_clk_prev_q;
  assign link_fall = ~clk_s & link_clk_prev_q;

  // Edge pulse generators
  edge_pulse_gen #(.LEN(EDGE_PULSE_CYCLES)) edge_pulse_flop_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig(link_rise),
    .busy(rise_busy)
  );

  edge_pulse_gen #(.LEN(EDGE_PULSE_CYCLES)) edge_pulse_flop_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig(link_fall),
    .busy(fall_busy)
  );

  assign rise_pulse_n = ~rise_busy;
  assign fall_pulse = fall_busy;

  // Sync register shifts on every link fall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_shift_register <= '0;
    end else if (link_fall) begin
      sync_shift_register <= {data_s, sync_shift_register[7:1]};
    end
  end

  assign txrx = {sync_shift_register[7], sync_shift_register[6]};
  assign sync_valid = shifted_q & rx_enable_q & ~framing_flip_flop & ~sync_shift_register[0] &
                      (sync_shift_register[5:1] == FIVE_ONES) & (txrx != TXRX_INVALID);
  assign five_ones_seen = shifted_q & framing_flip_flop & (sync_shift_register[7:3] == FIVE_ONES);
  assign eof_now = shifted_q & framing_flip_flop & (bit_cnt_q == FRAME_BITS);

  // Framing and bit counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      framing_flip_flop <= 1'b0;
    end else if (pfail_s || eof_now || five_ones_seen) begin
      framing_flip_flop <= 1'b0;
    end else if (sync_valid) begin
      framing_flip_flop <= 1'b1;
    end
  end

  assign input_clock_gate = framing_flip_flop & link_fall & (bit_cnt_q != FRAME_BITS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_q <= '0;
    end else if (sync_valid) begin
      bit_cnt_q <= '0;
    end else if (input_clock_gate) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_input_register <= '0;
    end else if (input_clock_gate) begin
      word_input_register <= {data_s, word_input_register[39:1]};
    end
  end

  // Comparator reference snapshot at each valid sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_word_q <= '0;
    end else if (sync_valid) begin
      prev_word_q <= word_input_register;
    end
  end

  // Mute from matching transmit/receive pairs
  assign txrx_compare_gate = sync_valid & (txrx == last_txrx_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_txrx_q <= '0;
      transmit_keying_n <= 1'b1;
    end else if (sync_valid) begin
      last_txrx_q <= txrx;
      if (txrx_compare_gate && txrx == TXRX_TRANSMIT) begin
        transmit_keying_n <= 1'b0;
      end else if (txrx_compare_gate && txrx == TXRX_RECEIVE) begin
        transmit_keying_n <= 1'b1;
      end
    end
  end

  // End-of-frame decisions
  assign word_identifier = word_input_register[WORD_ID_LSB +: WORD_ID_W];
  assign control_inhibit_bit = word_input_register[INHIBIT_POS];
  assign return_monitor_bit = word_input_register[RETMON_POS];
  assign cmp_ok = (word_input_register == prev_word_q);
  assign sff_bypass = ~sel_n_s & (word_identifier == WORD_ONE) & ~sync_shift_register[CHECK46_POS] &
                      sync_shift_register[CHECK47_POS];
  assign enable_now = cmp_ok | control_inhibit_bit | sff_bypass;
  assign monload_now = (word_identifier == WORD_ZERO) | ~enable_now | return_monitor_bit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eof_pulse <= 1'b0;
      enable_pulse <= 1'b0;
      monitor_load <= 1'b0;
    end else begin
      eof_pulse <= eof_now;
      enable_pulse <= eof_now & enable_now;
      monitor_load <= eof_now & monload_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_serial_entry <= 1'b0;
    end else if (eof_now && word_identifier == WORD_ONE) begin
      freq_serial_entry <= return_monitor_bit;
    end
  end

  // Consecutive comparison failures
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_cnt_q <= '0;
    end else if (eof_now) begin
      if (cmp_ok) begin
        fail_cnt_q <= '0;
      end else if (fail_cnt_q != FAIL_LIMIT) begin
        fail_cnt_q <= fail_cnt_q + 2'h1;
      end
    end
  end

  assign frame_error = (fail_cnt_q == FAIL_LIMIT);

  // Reply sync generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reply_sync_generator <= '0;
    end else if (eof_now) begin
      reply_sync_generator <= REPLY_SYNC;
    end else if (link_rise) begin
      reply_sync_generator <= {1'b0, reply_sync_generator[7:1]};
    end
  end

  assign reply_sync_data = reply_sync_generator[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frames_q <= '0;
    end else if (eof_now) begin
      frames_q <= frames_q + 16'h0001;
    end
  end

  // AXI4-Lite slave
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      rx_enable_q <= CTRL_RX_ENABLE_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_held_q && w_held_q && !s_axi_bvalid) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        case (awaddr_q)
          REG_CTRL: begin
            if (wstrb_q[0]) begin
              rx_enable_q <= wdata_q[0];
            end
          end
          REG_STATUS, REG_WORD_LO, REG_WORD_HI, REG_FRAMES: begin
          end
          default: begin
            s_axi_bresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {31'h0, rx_enable_q};
        REG_STATUS: s_axi_rdata <= {16'h0, sync_shift_register, 4'h0, freq_serial_entry, frame_error,
                                    transmit_keying_n, framing_flip_flop};
        REG_WORD_LO: s_axi_rdata <= word_input_register[31:0];
        REG_WORD_HI: s_axi_rdata <= {24'h0, word_input_register[39:32]};
        REG_FRAMES: s_axi_rdata <= {16'h0, frames_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sync_seen;
    sync_valid;
  endsequence

  sequence s_word0_end;
    eof_now && (word_identifier == WORD_ZERO);
  endsequence

  sequence s_bypass_end;
    eof_now && sff_bypass;
  endsequence

  AST_SYNC_STARTS_FRAME: assert property (s_sync_seen ##1 1'b1 |-> framing_flip_flop && bit_cnt_q == 6'h00)
    else $error("framing not started by valid sync");
  AST_SYNC_PATTERN: assert property (sync_valid |-> !sync_shift_register[0] && txrx != TXRX_INVALID)
    else $error("sync accepted with bad pattern");
  AST_EOF_COUNT: assert property (eof_pulse |-> $past(bit_cnt_q) == FRAME_BITS && !framing_flip_flop)
    else $error("end of frame without forty bits");
  AST_PFAIL_CLEARS: assert property (pfail_s |=> !framing_flip_flop)
    else $error("power fail did not clear framing");
  AST_WORD0_LOAD: assert property (s_word0_end |=> monitor_load && eof_pulse)
    else $error("word zero gave no monitor load");
  AST_INHIBIT_EN: assert property (eof_now && control_inhibit_bit |=> enable_pulse)
    else $error("control inhibit gave no enable");
  AST_SFF_EN: assert property (s_bypass_end |=> enable_pulse)
    else $error("single frame bypass gave no enable");
  AST_RETMON_LOAD: assert property (eof_now && return_monitor_bit |=> monitor_load)
    else $error("return monitor gave no monitor load");
  AST_MUTE_HOLD: assert property (!txrx_compare_gate |=> $stable(transmit_keying_n))
    else $error("mute changed without matching syncs");
  AST_REPLY_LOAD: assert property (eof_now |=> reply_sync_generator == REPLY_SYNC)
    else $error("reply sync not loaded at end of frame");
  AST_RISE_PULSE: assert property (link_rise |=> !rise_pulse_n [*8])
    else $error("rise pulse too short");
  AST_ERR_CLEAR: assert property (eof_now && cmp_ok |=> !frame_error ##1 !frame_error)
    else $error("error flag kept after success");

endmodule : serial_control_frame_receiver

// ### design/frame_rx_pkg.sv
// Constants shared by the serial control frame receiver
package frame_rx_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int EDGE_PULSE_NS = 6000;
  localparam int EDGE_PULSE_CYCLES = (EDGE_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : EDGE_PULSE_NS / CLK_PERIOD_NS;

  // Frame layout
  localparam logic [5:0] FRAME_BITS = 6'h28;
  localparam logic [4:0] FIVE_ONES = 5'h1F;
  localparam logic [7:0] REPLY_SYNC = 8'h3E;
  localparam logic [1:0] TXRX_TRANSMIT = 2'h1;
  localparam logic [1:0] TXRX_RECEIVE = 2'h2;
  localparam logic [1:0] TXRX_INVALID = 2'h3;
  localparam int CHECK46_POS = 6;
  localparam int CHECK47_POS = 7;
  localparam int INHIBIT_POS = 0;
  localparam int RETMON_POS = 1;
  localparam int WORD_ID_LSB = 2;
  localparam int WORD_ID_W = 4;
  localparam logic [3:0] WORD_ZERO = 4'h0;
  localparam logic [3:0] WORD_ONE = 4'h1;
  localparam logic [1:0] FAIL_LIMIT = 2'h3;

  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WORD_LO = 8'h08;
  localparam logic [7:0] REG_WORD_HI = 8'h0C;
  localparam logic [7:0] REG_FRAMES = 8'h10;
  localparam logic CTRL_RX_ENABLE_RST = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : frame_rx_pkg

// ### design/sync_2ff.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : sync_2ff

// ### design/edge_pulse_gen.sv
// Fixed-width pulse started by a one-cycle trigger
`timescale 1ns/1ps
module edge_pulse_gen #(
  parameter int LEN = 750
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Trigger and pulse
  input wire logic trig,
  output logic busy
);

  localparam int CW = $clog2(LEN + 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (trig) begin
      cnt_q <= CW'(LEN);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  assign busy = (cnt_q != '0);

endmodule : edge_pulse_gen

// ### test/remote_panel_model.sv
// Behavioural remote control panel driving the serial link
`timescale 1ns/1ps
module remote_panel_model (
  // Link pins
  output logic link_clk,
  output logic link_data
);
  // Link clock stands still low between frames
  initial begin
    link_clk = 1'h0;
    link_data = 1'h1;
  end

  task automatic set_clk(input logic v);
    link_clk = v;
  endtask : set_clk

  // Frame bit 0 first; pair never 11
  task automatic send_frame(input logic [1:0] txrx, input logic [39:0] word);
    logic [47:0] f;
    f = {word, txrx, 5'h1F, 1'h0};
    for (int i = 0; i < 48; i++) begin
      #47 link_data = f[i];
      #15.5 link_clk = 1'h1;
      #62.5 link_clk = 1'h0;
    end
    // Released line shows the inverse of the last bit
    #47 link_data = ~link_data;
  endtask : send_frame
endmodule : remote_panel_model

// ### test/tb.sv
// Self-checking testbench for the serial control frame receiver
`timescale 1ns/1ps
module tb;
  import frame_rx_pkg::*;
  localparam logic [39:0] W0 = 40'h2A5A5A5A40;
  localparam logic [39:0] W1 = 40'h15A5A5A504;
  localparam logic [39:0] WR = 40'h95A5A5A506;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic power_fail = 1'h0;
  logic sel_n = 1'h1;
  logic link_clk, link_data, tx_n, en, ml, eof, fse, ferr, rsd, rp_n, fp;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, last_en, last_ml;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int num_errors = 0, num_checks = 0, cycles = 0, eofs = 0, n;

  always #4 aclk = ~aclk;

  remote_panel_model u_remote_panel_model (.link_clk(link_clk), .link_data(link_data));

  serial_control_frame_receiver u_serial_control_frame_receiver (
    .aclk(aclk), .aresetn(aresetn), .link_clk_pin(link_clk), .link_data_pin(link_data),
    .power_fail_pin(power_fail), .single_freq_select_n_pin(sel_n),
    .transmit_keying_n(tx_n), .enable_pulse(en), .monitor_load(ml), .eof_pulse(eof),
    .freq_serial_entry(fse), .frame_error(ferr), .reply_sync_data(rsd),
    .rise_pulse_n(rp_n), .fall_pulse(fp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // Frame end monitor and hang limit
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (eof === 1'h1) begin
      eofs <= eofs + 1;
      last_en <= en;
      last_ml <= ml;
    end
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    do @(negedge aclk); while (bvalid !== 1'h1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge aclk); while (arready !== 1'h1);
    @(posedge aclk);
    arvalid <= 1'h0;
    do @(negedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask : axi_read

  // Expectation bits: frame end seen, enable, monitor load
  task automatic frame(input logic [1:0] tr, input logic [39:0] w, input logic [2:0] exp);
    int n0;
    n0 = eofs;
    u_remote_panel_model.send_frame(tr, w);
    repeat (20) @(posedge aclk);
    chk(40'(eofs - n0), 40'(exp[2]));
    if (exp[2]) chk({38'h0, last_en, last_ml}, {38'h0, exp[1:0]});
  endtask : frame

  // Single link edge, returns cycles the matching pulse lasts
  task automatic width(input logic lvl, output int w);
    w = 0;
    // Let pulses left over from the last frame run out first
    while ((lvl ? rp_n : ~fp) !== 1'h1) @(negedge aclk);
    u_remote_panel_model.set_clk(lvl);
    do @(negedge aclk); while ((lvl ? rp_n : ~fp) !== 1'h0);
    while ((lvl ? rp_n : ~fp) === 1'h0) begin
      w++;
      @(negedge aclk);
    end
  endtask : width

  initial begin
    repeat (20) @(posedge aclk);
    chk({38'h0, tx_n, rp_n}, 40'h3);
    aresetn <= 1'h1;
    axi_read(REG_CTRL, rd, rs);
    chk(40'(rd[0]), 40'(CTRL_RX_ENABLE_RST));
    frame(TXRX_RECEIVE, W0, 3'h5);
    chk({37'h0, rsd, tx_n, fse}, 40'h2);
    axi_read(REG_WORD_LO, rd, rs);
    chk(40'(rd), 40'(W0[31:0]));
    axi_read(REG_WORD_HI, rd, rs);
    chk(40'(rd[7:0]), 40'(W0[39:32]));
    axi_read(REG_STATUS, rd, rs);
    chk(40'(rd[15:0]), {24'h0, W0[39:32], 8'h02});
    width(1'h1, n);
    chk(40'(n), 40'(EDGE_PULSE_CYCLES));
    chk(40'(rsd), 40'h1);
    width(1'h0, n);
    chk(40'(n), 40'(EDGE_PULSE_CYCLES));
    frame(TXRX_TRANSMIT, W0, 3'h7);
    chk(40'(tx_n), 40'h1);
    frame(TXRX_TRANSMIT, W1, 3'h5);
    chk(40'(tx_n), 40'h0);
    frame(TXRX_TRANSMIT, W1, 3'h6);
    frame(2'h0, W1 | 40'h1, 3'h6);
    @(posedge aclk);
    sel_n <= 1'h0;
    frame(TXRX_RECEIVE, WR, 3'h7);
    chk({37'h0, tx_n, fse, ferr}, 40'h2);
    @(posedge aclk);
    sel_n <= 1'h1;
    frame(TXRX_RECEIVE, WR ^ 40'h40, 3'h5);
    chk({38'h0, tx_n, ferr}, 40'h3);
    @(posedge aclk);
    sel_n <= 1'h0;
    frame(TXRX_RECEIVE, W1 ^ 40'h40, 3'h5);
    chk(40'(fse), 40'h0);
    frame(TXRX_RECEIVE, W1 ^ 40'h40, 3'h6);
    chk(40'(ferr), 40'h0);
    frame(TXRX_RECEIVE, 40'hFF00, 3'h0);
    fork
      frame(TXRX_RECEIVE, W0, 3'h0);
      begin
        repeat (300) @(posedge aclk);
        power_fail <= 1'h1;
        repeat (4) @(posedge aclk);
        power_fail <= 1'h0;
      end
    join
    axi_read(REG_FRAMES, rd, rs);
    chk(40'(rd[15:0]), 40'h9);
    axi_write(REG_CTRL, 32'h0, rs);
    chk(40'(rs), 40'(RESP_OKAY));
    frame(TXRX_RECEIVE, W0, 3'h0);
    axi_write(REG_CTRL, 32'h1, rs);
    axi_read(8'h20, rd, rs);
    chk({rd, 6'h0, rs}, {32'h0, 6'h0, RESP_SLVERR});
    axi_write(8'h20, 32'h1, rs);
    chk(40'(rs), 40'(RESP_SLVERR));
    summarize();
  end
endmodule : tb
